// ===== shared/bos_pkg.sv
package bos_pkg;
  localparam int BOS_ADDR_W     = 32;
  localparam int BOS_DATA_W     = 16;
  localparam int BOS_BYTE_W     = 8;
  localparam int BOS_IDX_W      = 3;
  localparam int BOS_CNT_W      = 4;
  // Bytes per instruction word, as a shift
  localparam int BOS_WORD_SHIFT = 1;

  localparam logic [BOS_IDX_W-1:0] BOS_IDX_ONE = 3'h1;
  localparam logic [BOS_IDX_W-1:0] BOS_EXT_1   = 3'h1;
  localparam logic [BOS_IDX_W-1:0] BOS_EXT_2   = 3'h2;
  localparam logic [BOS_IDX_W-1:0] BOS_EXT_3   = 3'h3;
  localparam logic [BOS_IDX_W-1:0] BOS_REL_0   = 3'h0;
  localparam logic [BOS_IDX_W-1:0] BOS_REL_1   = 3'h1;
  localparam logic [BOS_IDX_W-1:0] BOS_REL_2   = 3'h2;
  localparam logic [BOS_CNT_W-1:0] BOS_CNT_ONE = 4'h1;

  typedef enum logic [3:0] {
    bit_clear_op, bit_invert_op, bit_set_op, bit_inverted_and_op,
    bit_inverted_load_op, bit_load_op, bit_or_op, bit_xor_op, bit_test_op,
    branch_greater_op, branch_less_equal_op, accumulator_clear_op,
    compare_op, decimal_adjust_op
  } bos_op_e;

  typedef enum logic [3:0] {
    mode_register, mode_indirect, mode_abs8, mode_abs16, mode_abs32,
    mode_imm8, mode_imm16, mode_imm32, mode_disp16, mode_none
  } bos_mode_e;

  typedef enum logic [2:0] {
    step_end, step_fetch_ext, step_read_ea, step_fetch_next,
    step_write_ea, step_internal, step_fetch_branch
  } bos_step_e;

  typedef struct packed {
    bos_step_e kind;
    logic      lock;
  } bos_step_s;

  typedef enum logic [1:0] {st_idle, st_issue, st_wait, st_internal} bos_state_e;
endpackage

// ===== shared/bos_cyc_if.sv
interface bos_cyc_if
  import bos_pkg::*;
#(
  parameter int ADDR_W = BOS_ADDR_W
) ();
  logic                  req;
  logic                  ready;
  logic                  done;
  logic                  write;
  logic                  byte_sz;
  logic                  lock;
  bos_step_e             step;
  bos_step_e             done_step;
  logic [ADDR_W-1:0]     addr;
  logic [BOS_BYTE_W-1:0] wdata;
  logic [BOS_DATA_W-1:0] rdata;

  modport seq (output req, write, byte_sz, lock, step, addr, wdata,
               input ready, done, done_step, rdata);
  modport port (input req, write, byte_sz, lock, step, addr, wdata,
                output ready, done, done_step, rdata);
endinterface

// ===== hdl/bos_bus_port.sv
module bos_bus_port
  import bos_pkg::*;
#(
  parameter int ADDR_W = BOS_ADDR_W
) (
  input  logic                  ref_clk_i,
  input  logic                  sys_rst_i,
  bos_cyc_if.port               cyc,
  input  logic                  bus_ack_i,
  input  logic [BOS_DATA_W-1:0] bus_rdata_i,
  output logic                  bus_req_o,
  output logic                  bus_write_o,
  output logic                  bus_byte_o,
  output logic                  bus_lock_o,
  output logic [ADDR_W-1:0]     bus_addr_o,
  output logic [BOS_BYTE_W-1:0] bus_wdata_o
);
  logic                  active_reg, active_next;
  logic                  write_reg, write_next;
  logic                  byte_reg, byte_next;
  logic                  lock_reg, lock_next;
  logic                  done_reg, done_next;
  logic [ADDR_W-1:0]     addr_reg, addr_next;
  logic [BOS_BYTE_W-1:0] wdata_reg, wdata_next;
  logic [BOS_DATA_W-1:0] rdata_reg, rdata_next;
  bos_step_e             step_reg, step_next;

  always_comb begin
    active_next = active_reg;
    write_next  = write_reg;
    byte_next   = byte_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    step_next   = step_reg;
    done_next   = 1'b0;
    // Mastership follows the sequencer's lock level one clock later, in step with the registered request
    lock_next   = cyc.lock; // RULE14
    if (!active_reg && cyc.req) begin
      active_next = 1'b1;
      write_next  = cyc.write;
      byte_next   = cyc.byte_sz;
      addr_next   = cyc.addr;
      wdata_next  = cyc.wdata;
      step_next   = cyc.step;
    end else if (active_reg && bus_ack_i) begin
      active_next = 1'b0;
      done_next   = 1'b1;
      if (!write_reg) begin
        rdata_next = bus_rdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      active_reg <= 1'b0;
      write_reg  <= 1'b0;
      byte_reg   <= 1'b0;
      lock_reg   <= 1'b0;
      done_reg   <= 1'b0;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      rdata_reg  <= '0;
      step_reg   <= step_end;
    end else begin
      active_reg <= active_next;
      write_reg  <= write_next;
      byte_reg   <= byte_next;
      lock_reg   <= lock_next;
      done_reg   <= done_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      step_reg   <= step_next;
    end
  end

  assign cyc.ready     = !active_reg;
  assign cyc.done      = done_reg;
  assign cyc.done_step = step_reg;
  assign cyc.rdata     = rdata_reg;
  assign bus_req_o     = active_reg;
  assign bus_write_o   = write_reg;
  assign bus_byte_o    = byte_reg;
  assign bus_lock_o    = lock_reg;
  assign bus_addr_o    = addr_reg;
  assign bus_wdata_o   = wdata_reg;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_req_hold_stable: assert property (bus_req_o && !bus_ack_i |=> bus_req_o && $stable(bus_addr_o))
    else $error("bus request dropped or address moved before ack");
  chk_write_locked: assert property (bus_req_o && bus_write_o |-> bus_lock_o) // RULE14
    else $error("operand write issued without bus lock");
  chk_lock_release: assert property ($fell(bus_lock_o) |-> $past(bus_write_o)) // RULE14
    else $error("bus lock released before operand write");
endmodule

// ===== hdl/bos_sequencer.sv
// Overview of operation
// (RULE1) Bit ops on a general register: one word fetch of the next instruction.
// (RULE2) Indirect bit modify: 2nd word, locked byte read, locked next fetch, byte write.
// (RULE3) Absolute 16 bit modify: extra 3rd word fetch, five cycles total.
// (RULE4) Absolute 32 bit modify: 2nd, 3rd, 4th words then locked triple, six cycles.
// (RULE5) Absolute 8 bit modify uses the same four cycles as indirect.
// (RULE6) Bit logic/load/test, indirect or abs8: 2nd word, unlocked byte read, next fetch.
// (RULE7) Bit logic/test abs16: 2nd, 3rd words, byte read, next fetch.
// (RULE8) Bit logic/test abs32: 2nd, 3rd, 4th words, byte read, next fetch.
// (RULE9) Branch d16: 2nd word, one internal state, fetch at branch target.
// (RULE10) Accumulator clear: next fetch then one internal state.
// (RULE11) Word compare immediate: 2nd word then next fetch.
// (RULE12) Long compare immediate: 2nd, 3rd words then next fetch.
// (RULE13) Register compares, byte immediate compare, decimal adjust: one next fetch.
// (RULE14) Locked cycles stay together; no other master between read and write.
module bos_sequencer
  import bos_pkg::*;
#(
  parameter int ADDR_W = BOS_ADDR_W
) (
  input  logic                  ref_clk_i,
  input  logic                  sys_rst_i,
  input  logic                  start_i,
  input  bos_op_e               op_i,
  input  bos_mode_e             mode_i,
  input  logic [ADDR_W-1:0]     pc_i,
  input  logic [ADDR_W-1:0]     ea_i,
  input  logic [ADDR_W-1:0]     branch_ea_i,
  input  logic [BOS_BYTE_W-1:0] wdata_i,
  input  logic                  bus_ack_i,
  input  logic [BOS_DATA_W-1:0] bus_rdata_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic                  illegal_o,
  output logic                  bus_req_o,
  output logic                  bus_write_o,
  output logic                  bus_byte_o,
  output logic                  bus_lock_o,
  output logic [ADDR_W-1:0]     bus_addr_o,
  output logic [BOS_BYTE_W-1:0] bus_wdata_o,
  output logic [BOS_DATA_W-1:0] rdata_o,
  output logic                  rdata_valid_o,
  output bos_step_e             rdata_step_o
);
  function automatic logic bos_is_bit(bos_op_e op);
    return op inside {bit_clear_op, bit_invert_op, bit_set_op, bit_inverted_and_op,
                      bit_inverted_load_op, bit_load_op, bit_or_op, bit_xor_op, bit_test_op};
  endfunction

  function automatic logic bos_is_mod(bos_op_e op);
    return op inside {bit_clear_op, bit_invert_op, bit_set_op};
  endfunction

  function automatic logic bos_legal(bos_op_e op, bos_mode_e md);
    logic ok;
    ok = 1'b0;
    if (bos_is_bit(op)) begin
      ok = md inside {mode_register, mode_indirect, mode_abs8, mode_abs16, mode_abs32};
    end else if (op inside {branch_greater_op, branch_less_equal_op}) begin
      ok = (md == mode_disp16);
    end else if (op == accumulator_clear_op) begin
      ok = (md == mode_none);
    end else if (op == compare_op) begin
      ok = md inside {mode_register, mode_imm8, mode_imm16, mode_imm32};
    end else begin
      ok = (md == mode_register);
    end
    return ok;
  endfunction

  // Bus step at position idx of the instruction's cycle sequence
  function automatic bos_step_s bos_step_at(bos_op_e op, bos_mode_e md, logic [BOS_IDX_W-1:0] idx);
    bos_step_s            s;
    logic [BOS_IDX_W-1:0] n_ext;
    logic [BOS_IDX_W-1:0] rel;
    s = '{kind: step_end, lock: 1'b0};
    case (md)
      mode_indirect, mode_abs8, mode_imm16, mode_disp16: n_ext = BOS_EXT_1;
      mode_abs16, mode_imm32: n_ext = BOS_EXT_2;
      mode_abs32: n_ext = BOS_EXT_3;
      default: n_ext = '0;
    endcase
    rel = idx - n_ext;
    if (idx < n_ext) begin
      s.kind = step_fetch_ext; // RULE3 RULE4 RULE7 RULE8 RULE11 RULE12
    end else if (bos_is_bit(op) && md != mode_register) begin
      case (rel)
        BOS_REL_0: s = '{kind: step_read_ea, lock: bos_is_mod(op)}; // RULE2 RULE5 RULE6
        BOS_REL_1: s = '{kind: step_fetch_next, lock: bos_is_mod(op)}; // RULE2 RULE6
        BOS_REL_2: s = bos_is_mod(op) ? '{kind: step_write_ea, lock: 1'b1} : s; // RULE2 RULE14
        default: s = '{kind: step_end, lock: 1'b0};
      endcase
    end else if (md == mode_disp16) begin
      case (rel)
        BOS_REL_0: s.kind = step_internal; // RULE9
        BOS_REL_1: s.kind = step_fetch_branch; // RULE9
        default: s.kind = step_end;
      endcase
    end else if (op == accumulator_clear_op) begin
      case (rel)
        BOS_REL_0: s.kind = step_fetch_next; // RULE10
        BOS_REL_1: s.kind = step_internal; // RULE10
        default: s.kind = step_end;
      endcase
    end else if (rel == BOS_REL_0) begin
      s.kind = step_fetch_next; // RULE1 RULE13
    end
    return s;
  endfunction

  function automatic bos_state_e bos_route(bos_step_e k);
    if (k == step_end) begin
      return st_idle;
    end
    return (k == step_internal) ? st_internal : st_issue;
  endfunction

  bos_cyc_if #(.ADDR_W(ADDR_W)) cyc ();

  bos_state_e           state_reg, state_next;
  bos_op_e              op_reg, op_next;
  bos_mode_e            amode_reg, amode_next;
  logic [ADDR_W-1:0]    pc_reg, pc_next;
  logic [ADDR_W-1:0]    ea_reg, ea_next;
  logic [ADDR_W-1:0]    bea_reg, bea_next;
  logic [BOS_IDX_W-1:0] idx_reg, idx_next;
  logic [BOS_IDX_W-1:0] ext_reg, ext_next;
  logic                 done_reg, done_next;
  logic                 illegal_reg, illegal_next;
  logic [BOS_CNT_W-1:0] iss_cnt_reg, iss_cnt_next;
  logic [BOS_CNT_W-1:0] int_cnt_reg, int_cnt_next;
  bos_step_s            cur;
  bos_step_s            nxt;
  logic [BOS_IDX_W-1:0] ext_inc;

  assign cur     = bos_step_at(op_reg, amode_reg, idx_reg);
  assign nxt     = bos_step_at(op_reg, amode_reg, idx_reg + BOS_IDX_ONE);
  assign ext_inc = ext_reg + BOS_IDX_ONE;

  always_comb begin
    state_next   = state_reg;
    op_next      = op_reg;
    amode_next   = amode_reg;
    pc_next      = pc_reg;
    ea_next      = ea_reg;
    bea_next     = bea_reg;
    idx_next     = idx_reg;
    ext_next     = ext_reg;
    iss_cnt_next = iss_cnt_reg;
    int_cnt_next = int_cnt_reg;
    done_next    = 1'b0;
    illegal_next = 1'b0;
    unique case (state_reg)
      st_idle: begin
        if (start_i) begin
          op_next      = op_i;
          amode_next   = mode_i;
          pc_next      = pc_i;
          ea_next      = ea_i;
          bea_next     = branch_ea_i;
          idx_next     = '0;
          ext_next     = '0;
          iss_cnt_next = '0;
          int_cnt_next = '0;
          illegal_next = !bos_legal(op_i, mode_i);
          if (bos_legal(op_i, mode_i)) begin
            state_next = bos_route(bos_step_at(op_i, mode_i, '0).kind);
          end
        end
      end
      st_issue: begin
        if (cyc.ready) begin
          state_next   = st_wait;
          iss_cnt_next = iss_cnt_reg + BOS_CNT_ONE;
          if (cur.kind == step_fetch_ext) begin
            ext_next = ext_inc;
          end
        end
      end
      st_wait: begin
        if (cyc.done) begin
          idx_next   = idx_reg + BOS_IDX_ONE;
          state_next = bos_route(nxt.kind);
          done_next  = (nxt.kind == step_end);
        end
      end
      st_internal: begin
        // One state with no bus access
        int_cnt_next = int_cnt_reg + BOS_CNT_ONE; // RULE9 RULE10
        idx_next     = idx_reg + BOS_IDX_ONE;
        state_next   = bos_route(nxt.kind);
        done_next    = (nxt.kind == step_end);
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_reg   <= st_idle;
      op_reg      <= bit_test_op;
      amode_reg   <= mode_register;
      pc_reg      <= '0;
      ea_reg      <= '0;
      bea_reg     <= '0;
      idx_reg     <= '0;
      ext_reg     <= '0;
      iss_cnt_reg <= '0;
      int_cnt_reg <= '0;
      done_reg    <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      amode_reg   <= amode_next;
      pc_reg      <= pc_next;
      ea_reg      <= ea_next;
      bea_reg     <= bea_next;
      idx_reg     <= idx_next;
      ext_reg     <= ext_next;
      iss_cnt_reg <= iss_cnt_next;
      int_cnt_reg <= int_cnt_next;
      done_reg    <= done_next;
      illegal_reg <= illegal_next;
    end
  end

  assign cyc.req     = (state_reg == st_issue);
  assign cyc.step    = cur.kind;
  assign cyc.write   = (cur.kind == step_write_ea); // RULE2
  assign cyc.byte_sz = cur.kind inside {step_read_ea, step_write_ea};
  assign cyc.lock    = (state_reg != st_idle) && cur.lock; // RULE14
  assign cyc.wdata   = wdata_i;
  // Instruction words sit at pc + 2 * (words already fetched + 1)
  assign cyc.addr    = cur.kind inside {step_read_ea, step_write_ea} ? ea_reg :
                       (cur.kind == step_fetch_branch) ? bea_reg : // RULE9
                       pc_reg + (ADDR_W'(ext_inc) << BOS_WORD_SHIFT);

  bos_bus_port #(.ADDR_W(ADDR_W)) u_port (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .cyc         (cyc.port),
    .bus_ack_i   (bus_ack_i),
    .bus_rdata_i (bus_rdata_i),
    .bus_req_o   (bus_req_o),
    .bus_write_o (bus_write_o),
    .bus_byte_o  (bus_byte_o),
    .bus_lock_o  (bus_lock_o),
    .bus_addr_o  (bus_addr_o),
    .bus_wdata_o (bus_wdata_o)
  );

  assign busy_o        = (state_reg != st_idle);
  assign done_o        = done_reg;
  assign illegal_o     = illegal_reg;
  assign rdata_o       = cyc.rdata;
  assign rdata_valid_o = cyc.done;
  assign rdata_step_o  = cyc.done_step;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_reg_bit_one: assert property (done_o && bos_is_bit(op_reg) && amode_reg == mode_register
    |-> iss_cnt_reg == 4'h1 && int_cnt_reg == 4'h0) // RULE1
    else $error("register bit op not one fetch");
  chk_mod_short_four: assert property (done_o && bos_is_mod(op_reg)
    && amode_reg inside {mode_indirect, mode_abs8} |-> iss_cnt_reg == 4'h4) // RULE2 RULE5
    else $error("short bit modify not four cycles");
  chk_mod_abs16_five: assert property (done_o && bos_is_mod(op_reg) && amode_reg == mode_abs16
    |-> iss_cnt_reg == 4'h5) // RULE3
    else $error("abs16 bit modify not five cycles");
  chk_mod_abs32_six: assert property (done_o && bos_is_mod(op_reg) && amode_reg == mode_abs32
    |-> iss_cnt_reg == 4'h6) // RULE4
    else $error("abs32 bit modify not six cycles");
  chk_test_short_three: assert property (done_o && bos_is_bit(op_reg) && !bos_is_mod(op_reg)
    && amode_reg inside {mode_indirect, mode_abs8} |-> iss_cnt_reg == 4'h3) // RULE6
    else $error("short bit test not three cycles");
  chk_test_long_count: assert property (done_o && bos_is_bit(op_reg) && !bos_is_mod(op_reg)
    && amode_reg inside {mode_abs16, mode_abs32}
    |-> iss_cnt_reg == ((amode_reg == mode_abs16) ? 4'h4 : 4'h5)) // RULE7 RULE8
    else $error("absolute bit test cycle count wrong");
  chk_test_no_lock: assert property (cyc.req && bos_is_bit(op_reg) && !bos_is_mod(op_reg)
    |-> !cyc.lock && !cyc.write) // RULE6
    else $error("bit test issued locked or write cycle");
  chk_branch_gap: assert property (cyc.req && cyc.ready && cur.kind == step_fetch_branch
    |-> iss_cnt_reg == 4'h1 && int_cnt_reg == 4'h1 ##1 !cyc.req[*2]) // RULE9
    else $error("branch target fetch not after one internal state");
  chk_acc_clear_seq: assert property (done_o && op_reg == accumulator_clear_op
    |-> iss_cnt_reg == 4'h1 && $past(state_reg) == st_internal) // RULE10
    else $error("accumulator clear sequence wrong");
  chk_cmp_imm_count: assert property (done_o && op_reg == compare_op
    |-> iss_cnt_reg == ((amode_reg == mode_imm16) ? 4'h2 : (amode_reg == mode_imm32) ? 4'h3 : 4'h1))
    else $error("compare cycle count wrong"); // RULE11 RULE12 RULE13
  chk_daa_single: assert property (done_o && op_reg == decimal_adjust_op |-> iss_cnt_reg == 4'h1)
    else $error("decimal adjust not one fetch"); // RULE13
  chk_lock_contig: assert property (cyc.req && cyc.ready && cur.kind == step_read_ea && cur.lock
    |=> cyc.lock[*3]) // RULE14
    else $error("lock dropped inside read-modify-write");
endmodule

// ===== dv/bos_mem_model.sv
module bos_mem_model
  import bos_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  slow_i,
  input  wire logic                  bus_req_i,
  input  wire logic [BOS_ADDR_W-1:0] bus_addr_i,
  output logic                       bus_ack_o,
  output logic [BOS_DATA_W-1:0]      bus_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] wait_cnt;

  initial begin
    bus_ack_o   = 1'b0;
    bus_rdata_o = 16'h0000;
    wait_cnt    = 3'h0;
  end

  // Single master on this bus, so a locked sequence is never split
  // Data lines toggle whenever no read answer is due
  always @(negedge ref_clk_i) begin
    if (sys_rst_i || !bus_req_i || bus_ack_o) begin
      bus_ack_o   <= 1'b0;
      wait_cnt    <= slow_i ? 3'h3 : 3'h0;
      bus_rdata_o <= ~bus_rdata_o;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt    <= wait_cnt - 3'h1;
      bus_rdata_o <= ~bus_rdata_o;
    end else begin
      bus_ack_o   <= 1'b1;
      bus_rdata_o <= bus_addr_i[15:0] ^ 16'ha5c3;
    end
  end
endmodule

// ===== dv/tb_bit_op_bus_cycle_sequencer.sv
module tb_bit_op_bus_cycle_sequencer
  import bos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic                  w;
    logic                  b;
    logic                  l;
    logic [BOS_ADDR_W-1:0] a;
    logic [BOS_BYTE_W-1:0] d;
  } bos_tb_cyc_s;

  logic                  ref_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  start   = 1'b0;
  bos_op_e               op      = bit_test_op;
  bos_mode_e             mode    = mode_register;
  logic [BOS_ADDR_W-1:0] pc      = 32'h0000_0000;
  logic [BOS_ADDR_W-1:0] ea      = 32'h0000_0000;
  logic [BOS_ADDR_W-1:0] bea     = 32'h0000_0000;
  logic [BOS_BYTE_W-1:0] wdata   = 8'h00;
  logic                  slow    = 1'b0;
  logic                  ack;
  logic [BOS_DATA_W-1:0] rdata;
  logic                  busy;
  logic                  done;
  logic                  illegal;
  logic                  req;
  logic                  wr;
  logic                  byt;
  logic                  lock;
  logic [BOS_ADDR_W-1:0] addr;
  logic [BOS_BYTE_W-1:0] bwdata;
  logic [BOS_DATA_W-1:0] rd_o;
  logic                  rd_valid;
  bos_step_e             rd_step;
  logic [BOS_ADDR_W-1:0] last_addr = 32'h0000_0000;
  logic [31:0]           seed      = 32'hdbcc_868c;
  int                    num_errors = 0;
  int                    compares   = 0;
  bos_tb_cyc_s           got_q[$];
  bos_tb_cyc_s           exp_q[$];

  always #20 ref_clk = ~ref_clk;

  bos_sequencer #(.ADDR_W(BOS_ADDR_W)) dut_u (
    .ref_clk_i    (ref_clk),
    .sys_rst_i    (sys_rst),
    .start_i      (start),
    .op_i         (op),
    .mode_i       (mode),
    .pc_i         (pc),
    .ea_i         (ea),
    .branch_ea_i  (bea),
    .wdata_i      (wdata),
    .bus_ack_i    (ack),
    .bus_rdata_i  (rdata),
    .busy_o       (busy),
    .done_o       (done),
    .illegal_o    (illegal),
    .bus_req_o    (req),
    .bus_write_o  (wr),
    .bus_byte_o   (byt),
    .bus_lock_o   (lock),
    .bus_addr_o   (addr),
    .bus_wdata_o  (bwdata),
    .rdata_o      (rd_o),
    .rdata_valid_o(rd_valid),
    .rdata_step_o (rd_step)
  );

  bos_mem_model mem_u (
    .ref_clk_i  (ref_clk),
    .sys_rst_i  (sys_rst),
    .slow_i     (slow),
    .bus_req_i  (req),
    .bus_addr_i (addr),
    .bus_ack_o  (ack),
    .bus_rdata_o(rdata)
  );

  function automatic logic [31:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h8020_0003) : (seed >> 1);
    return seed;
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Completed bus cycles and returned read data
  always @(posedge ref_clk) begin
    if (req && ack) begin
      got_q.push_back({wr, byt, lock, addr, wr ? bwdata : 8'h00});
      last_addr <= addr;
    end
    if (rd_valid && rd_step != step_write_ea)
      check({48'h0, rd_o}, {48'h0, last_addr[15:0] ^ 16'ha5c3});
  end

  function automatic int ext_of(input bos_mode_e m);
    case (m)
      mode_indirect, mode_abs8, mode_imm16, mode_disp16: return 1;
      mode_abs16, mode_imm32: return 2;
      mode_abs32: return 3;
      default: return 0;
    endcase
  endfunction

  function automatic bit legal(input bos_op_e o, input bos_mode_e m);
    case (o)
      branch_greater_op, branch_less_equal_op: return m == mode_disp16;
      accumulator_clear_op: return m == mode_none;
      compare_op: return m inside {mode_register, mode_imm8, mode_imm16, mode_imm32};
      decimal_adjust_op: return m == mode_register;
      default: return m inside {mode_register, mode_indirect, mode_abs8, mode_abs16, mode_abs32};
    endcase
  endfunction

  task automatic build(input bos_op_e o, input bos_mode_e m, input logic [31:0] p, input logic [31:0] e,
                       input logic [31:0] b, input logic [7:0] d);
    int n;
    bit md;
    n = ext_of(m);
    md = (o inside {bit_clear_op, bit_invert_op, bit_set_op}) && m != mode_register;
    exp_q = {};
    if (!legal(o, m))
      return;
    for (int i = 1; i <= n; i++)
      exp_q.push_back({3'h0, p + 32'(2 * i), 8'h00});
    if (o inside {branch_greater_op, branch_less_equal_op}) begin
      exp_q.push_back({3'h0, b, 8'h00});
    end else begin
      if (m inside {mode_indirect, mode_abs8, mode_abs16, mode_abs32})
        exp_q.push_back({1'b0, 1'b1, md, e, 8'h00});
      exp_q.push_back({2'h0, md, p + 32'(2 * (n + 1)), 8'h00});
      if (md)
        exp_q.push_back({3'h7, e, d});
    end
  endtask

  // Issues one instruction at a falling edge, returns in its done or refusal cycle
  task automatic run(input bos_op_e o, input bos_mode_e m);
    logic [31:0] t;
    int          k;
    t = rnd();
    start = 1'b1;
    op    = o;
    mode  = m;
    pc    = rnd() & 32'hffff_fffe;
    ea    = rnd();
    bea   = rnd() & 32'hffff_fffe;
    wdata = t[15:8];
    slow  = t[0];
    build(o, m, pc, ea, bea, wdata);
    got_q = {};
    @(negedge ref_clk);
    for (k = 0; k < 200; k++) begin
      if (done || illegal)
        break;
      // Requests while busy must be ignored
      t = rnd();
      start = t[0];
      op    = bos_op_e'(4'(t[4:1] % 4'he));
      mode  = bos_mode_e'(4'(t[8:5] % 4'ha));
      pc    = rnd();
      @(negedge ref_clk);
    end
    if (k == 200) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      complete_run();
    end
    check({63'h0, illegal}, {63'h0, !legal(o, m)});
    check(64'(got_q.size()), 64'(exp_q.size()));
    foreach (exp_q[i])
      check(got_q[i], exp_q[i]);
  endtask

  initial begin
    logic [31:0] t;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    check({59'h0, busy, done, illegal, req, lock}, 64'h0);
    for (int o = 0; o < 14; o++)
      for (int m = 0; m < 10; m++)
        run(bos_op_e'(4'(o)), bos_mode_e'(4'(m)));
    start = 1'b0;
    $display("test sweep ended");
    for (int i = 0; i < 150; i++) begin
      t = rnd();
      run(bos_op_e'(4'(t[3:0] % 4'he)), bos_mode_e'(4'(t[7:4] % 4'ha)));
    end
    start = 1'b0;
    $display("test random ended");
    run(bit_set_op, mode_abs32);
    start = 1'b0;
    repeat (5) @(negedge ref_clk);
    // Reset while idle, five cycles after the locked abs32 sequence has finished
    sys_rst = 1'b1;
    @(negedge ref_clk);
    sys_rst = 1'b0;
    check({58'h0, busy, done, illegal, req, lock, rd_valid}, 64'h0);
    check(64'(rd_step), 64'(step_end));
    run(bit_invert_op, mode_indirect);
    start = 1'b0;
    $display("test reset ended");
    complete_run();
  end
endmodule
